/* nwm_pkg.sv */
package nwm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned STROBE_NS = 450;
  localparam int unsigned PERIOD_NS = 2000;
  localparam int unsigned DONE_MAX_NS = 500;
  localparam int unsigned HOLD_NS = 150;
  localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned PERIOD_CYC = (PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned DONE_MAX_CYC = (DONE_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned HOLD_CYC = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MULTI_READS = 7;
  localparam logic [3:0] SEL_ON = 4'hf;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_PER = 8'h10;
  localparam logic [7:0] OFF_RDAT = 8'h14;
  // ctrl fields
  localparam int unsigned CT_START = 0;
  localparam int unsigned CT_STOP = 1;
  localparam int unsigned CT_RESET = 2;
  localparam int unsigned CT_WRITE = 3;
  localparam int unsigned CT_SEQADR = 4;
  localparam int unsigned CT_SEQDAT = 5;
  localparam int unsigned CT_READ7 = 6;
  localparam int unsigned CT_SEL = 8;
  typedef enum logic [2:0] {
    NWM_IDLE, NWM_STROBE, NWM_WAIT, NWM_GAP
  } nwm_state_e;
endpackage : nwm_pkg

/* nwm_host.sv */
`timescale 1ns/1ps
module nwm_host
  import nwm_pkg::*;
#(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 18
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory unit pins
  output logic strobe,
  output logic rd_wr_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] data_input_line,
  output logic [3:0] unit_sel,
  input wire logic read_done_n_i,
  output logic read_done_n_o,
  output logic read_done_n_oe,
  input wire logic [DW-1:0] dout_n_i,
  output logic [DW-1:0] dout_n_o,
  output logic [DW-1:0] dout_n_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // pin receive: host only pulls up, never sinks open-collector lines
  assign read_done_n_o = 1'b1;
  assign read_done_n_oe = 1'b0;
  assign dout_n_o = '1;
  assign dout_n_oe = '0;

  logic done_m_ff, done_s_ff, done_d_ff;
  logic [DW-1:0] dout_m_ff, dout_s_ff;
  // two-flop sync of unit outputs
  always_ff @(posedge clk) begin
    done_m_ff <= read_done_n_i;
    done_s_ff <= done_m_ff;
    done_d_ff <= done_s_ff;
    dout_m_ff <= dout_n_i;
    dout_s_ff <= dout_m_ff;
  end
  // synced read-done edge; the line idles high, so no false edge after reset
  wire done_fall = done_d_ff & ~done_s_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic run_ff, nxt_run;
  logic wr_mode_ff, nxt_wr_mode, seq_adr_ff, nxt_seq_adr;
  logic seq_dat_ff, nxt_seq_dat, read7_ff, nxt_read7;
  logic err_ff, nxt_err, pass_ff, nxt_pass;
  logic [3:0] sel_ff, nxt_sel;
  logic [DW-1:0] man_ff, nxt_man, rdat_ff, nxt_rdat, exp_ff, nxt_exp;
  logic [AW-1:0] adr_ff, nxt_adr, err_adr_ff, nxt_err_adr;
  logic [15:0] per_ff, nxt_per;
  logic [1:0] phase_ff, nxt_phase; // 0 w0,1 r0,2 w1,3 r1
  logic [2:0] rcnt_ff, nxt_rcnt;
  logic [15:0] cnt_ff, nxt_cnt;
  logic acc_wr_ff, nxt_acc_wr;
  logic [DW-1:0] wdat_ff, nxt_wdat;
  nwm_state_e st_ff, nxt_st;

  // apb decode; a zero-wait slave keeps the bus master simple
  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  assign pready = 1'b1; // zero-wait slave
  assign pslverr = 1'b0;

  logic [31:0] prdata_ff, nxt_prdata;
  // read word picked in the setup cycle and held in a flop, so the
  // access cycle still answers with no wait state
  always_comb begin
    nxt_prdata = prdata_ff;
    if (psel && !penable) begin
      case (paddr)
        OFF_CTRL: nxt_prdata = {20'h0_0000, sel_ff, 1'b0, read7_ff, seq_dat_ff, seq_adr_ff,
                                wr_mode_ff, 3'h0};
        OFF_DATA: nxt_prdata = {14'h0000, man_ff};
        OFF_ADDR: nxt_prdata = {20'h0_0000, adr_ff};
        OFF_STAT: nxt_prdata = {18'h0_0000, err_adr_ff, pass_ff, err_ff};
        OFF_PER: nxt_prdata = {16'h0000, per_ff};
        OFF_RDAT: nxt_prdata = {14'h0000, rdat_ff};
        default: nxt_prdata = '0; // unmapped reads zero
      endcase
    end
  end

  // read word register
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // the expected word for current phase
  function automatic logic [DW-1:0] pat(input logic [1:0] ph, input logic seqd,
                                        input logic [DW-1:0] manual_pattern);
    if (!seqd) return manual_pattern;
    return ph[1] ? '1 : '0;
  endfunction

  // direction and end of sweep for the coming access
  wire is_rd_phase = seq_dat_ff ? phase_ff[0] : ~wr_mode_ff;
  wire last_adr = &adr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next-state
  always_comb begin
    nxt_run = run_ff;
    nxt_wr_mode = wr_mode_ff;
    nxt_seq_adr = seq_adr_ff;
    nxt_seq_dat = seq_dat_ff;
    nxt_read7 = read7_ff;
    nxt_sel = sel_ff;
    nxt_man = man_ff;
    nxt_adr = adr_ff;
    nxt_per = per_ff;
    nxt_err = err_ff;
    nxt_pass = pass_ff;
    nxt_err_adr = err_adr_ff;
    nxt_rdat = rdat_ff;
    nxt_exp = exp_ff;
    nxt_phase = phase_ff;
    nxt_rcnt = rcnt_ff;
    nxt_cnt = cnt_ff;
    nxt_acc_wr = acc_wr_ff;
    nxt_wdat = wdat_ff;
    nxt_st = st_ff;
    if (wr_acc && paddr == OFF_CTRL) begin
      nxt_wr_mode = pwdata[CT_WRITE];
      nxt_seq_adr = pwdata[CT_SEQADR];
      nxt_seq_dat = pwdata[CT_SEQDAT];
      nxt_read7 = pwdata[CT_READ7];
      nxt_sel = pwdata[CT_SEL+:4];
      if (pwdata[CT_RESET]) begin
        nxt_err = 1'b0;
        nxt_pass = 1'b0;
        nxt_phase = '0;
        nxt_rcnt = '0;
      end
      // start and stop in one write leave the sequencer stopped
      if (pwdata[CT_START]) nxt_run = 1'b1;
      if (pwdata[CT_STOP]) nxt_run = 1'b0;
    end
    if (wr_acc && paddr == OFF_DATA) nxt_man = pwdata[DW-1:0];
    // address frozen while strobe is high; a write then is dropped
    if (wr_acc && paddr == OFF_ADDR && st_ff != NWM_STROBE) nxt_adr = pwdata[AW-1:0];
    if (wr_acc && paddr == OFF_PER) nxt_per = pwdata[15:0];
    // events below follow the register writes, so a sequencer event beats a register write
    case (st_ff)
      // launch a new access unless stopped or an error is latched
      NWM_IDLE: begin
        if (run_ff && !err_ff) begin
          nxt_acc_wr = ~is_rd_phase;
          nxt_wdat = pat(phase_ff, seq_dat_ff, man_ff);
          nxt_exp = pat(phase_ff, seq_dat_ff, man_ff);
          nxt_cnt = '0;
          nxt_st = NWM_STROBE;
        end
      end
      NWM_STROBE: begin
        nxt_cnt = cnt_ff + 16'd1;
        // read-done expected within the window from strobe rise
        if (done_fall && !acc_wr_ff) begin
          nxt_rdat = ~dout_s_ff; // lines low = data one, sampled at done edge
          if (~dout_s_ff != exp_ff) begin
            nxt_err = 1'b1;
            nxt_err_adr = adr_ff;
          end
          nxt_acc_wr = 1'b1; // marks read answered
        end
        if (cnt_ff == 16'(STROBE_CYC - 1)) nxt_st = NWM_WAIT;
      end
      NWM_WAIT: begin
        nxt_cnt = cnt_ff + 16'd1;
        if (done_fall && !acc_wr_ff) begin
          nxt_rdat = ~dout_s_ff;
          if (~dout_s_ff != exp_ff) begin
            nxt_err = 1'b1;
            nxt_err_adr = adr_ff;
          end
          nxt_acc_wr = 1'b1;
        end
        // no read-done in time: unselected or faulty unit
        if (!acc_wr_ff && cnt_ff == 16'(DONE_MAX_CYC + 3)) begin
          nxt_err = 1'b1;
          nxt_err_adr = adr_ff;
          nxt_acc_wr = 1'b1;
        end
        if (acc_wr_ff && cnt_ff >= 16'(DONE_MAX_CYC + 3)) nxt_st = NWM_GAP;
      end
      // gap: period counted from strobe rise, then one idle cycle
      default: begin
        nxt_cnt = cnt_ff + 16'd1;
        if (cnt_ff >= per_ff - 16'd1) begin
          nxt_st = NWM_IDLE;
          if (seq_dat_ff) begin
            if (phase_ff[0] && read7_ff && rcnt_ff != 3'(MULTI_READS - 1))
              nxt_rcnt = rcnt_ff + 3'd1;
            else begin
              nxt_rcnt = '0;
              nxt_phase = phase_ff + 2'd1;
              if (phase_ff == 2'd3 && seq_adr_ff) nxt_adr = adr_ff + 1'b1;
            end
          end else if (seq_adr_ff) begin
            nxt_adr = adr_ff + 1'b1;
            if (last_adr && wr_mode_ff) begin
              nxt_run = 1'b0;
              nxt_pass = 1'b1;
            end
          end else nxt_run = 1'b0;
        end
      end
    endcase
    // a latched error halts the sweep
    if (err_ff) nxt_run = 1'b0;
  end

  // sequencer registers; reset leaves write mode, sequential address, unit on
  always_ff @(posedge clk) begin
    if (rst) begin
      run_ff <= 1'b0;
      wr_mode_ff <= 1'b1;
      seq_adr_ff <= 1'b1;
      seq_dat_ff <= 1'b0;
      read7_ff <= 1'b0;
      sel_ff <= SEL_ON;
      man_ff <= '0;
      adr_ff <= '0;
      per_ff <= 16'(PERIOD_CYC);
      err_ff <= 1'b0;
      pass_ff <= 1'b0;
      err_adr_ff <= '0;
      rdat_ff <= '0;
      exp_ff <= '0;
      phase_ff <= '0;
      rcnt_ff <= '0;
      cnt_ff <= '0;
      acc_wr_ff <= 1'b0;
      wdat_ff <= '0;
      st_ff <= NWM_IDLE;
    end else begin
      run_ff <= nxt_run;
      wr_mode_ff <= nxt_wr_mode;
      seq_adr_ff <= nxt_seq_adr;
      seq_dat_ff <= nxt_seq_dat;
      read7_ff <= nxt_read7;
      sel_ff <= nxt_sel;
      man_ff <= nxt_man;
      adr_ff <= nxt_adr;
      per_ff <= nxt_per;
      err_ff <= nxt_err;
      pass_ff <= nxt_pass;
      err_adr_ff <= nxt_err_adr;
      rdat_ff <= nxt_rdat;
      exp_ff <= nxt_exp;
      phase_ff <= nxt_phase;
      rcnt_ff <= nxt_rcnt;
      cnt_ff <= nxt_cnt;
      acc_wr_ff <= nxt_acc_wr;
      wdat_ff <= nxt_wdat;
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive; rd/wr level held from idle until next idle
  logic strobe_ff, nxt_strobe, rdwr_ff, nxt_rdwr;
  // strobe and level leave flops on the same edge that the state moves,
  // so the unit never sees a glitch from the decode
  always_comb begin
    nxt_strobe = (nxt_st == NWM_STROBE);
    nxt_rdwr = rdwr_ff;
    if (st_ff == NWM_IDLE && nxt_st == NWM_STROBE) begin
      nxt_rdwr = is_rd_phase;
    end
  end

  // pin registers
  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_ff <= 1'b0;
      rdwr_ff <= 1'b1;
    end else begin
      strobe_ff <= nxt_strobe;
      rdwr_ff <= nxt_rdwr;
    end
  end
  assign strobe = strobe_ff;
  assign rd_wr_n = rdwr_ff;
  assign addr = adr_ff;
  assign data_input_line = wdat_ff;
  assign unit_sel = sel_ff;
endmodule : nwm_host

/* nwm_checker_assertions.sv */
`timescale 1ns/1ps
module nwm_checker
  import nwm_pkg::*;
(
  // clock and apb
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // unit pins
  input wire logic strobe,
  input wire logic rd_wr_n,
  input wire logic [11:0] addr,
  input wire logic [17:0] data_input_line,
  input wire logic [3:0] unit_sel,
  input wire logic read_done_n_oe,
  input wire logic [17:0] dout_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] hi_ff;
  logic [7:0] nxt_hi;
  // strobe high time; a counter avoids a long repetition
  always_comb nxt_hi = strobe ? hi_ff + 8'h01 : 8'h00;
  always_ff @(posedge clk) hi_ff <= rst ? 8'h00 : nxt_hi;
  sequence lead_s;
    !strobe ##1 strobe;
  endsequence
  ////////////
  strobe_len_a: assert property ($fell(strobe) |-> hi_ff == STROBE_CYC)
    else $error("strobe width wrong");
  strobe_hold_a: assert property (lead_s |-> strobe[*8])
    else $error("strobe cut short");
  strobe_gap_a: assert property ($fell(strobe) |=> !strobe)
    else $error("strobes merged");
  access_stable_a: assert property (strobe && $past(strobe) |->
    $stable({rd_wr_n, addr, data_input_line, unit_sel})) else $error("access moved");
  no_drive_a: assert property (!read_done_n_oe && dout_n_oe == 18'h0_0000)
    else $error("host drives unit outputs");
  reset_idle_a: assert property ($fell(rst) |->
    !strobe && rd_wr_n && unit_sel == SEL_ON) else $error("bad reset levels");
  apb_ready_a: assert property (psel |-> pready && !pslverr)
    else $error("apb not ready");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 8'h18 |->
    prdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule : nwm_checker
bind nwm_host nwm_checker nwm_checker_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .strobe(strobe), .rd_wr_n(rd_wr_n), .addr(addr), .data_input_line(data_input_line),
  .unit_sel(unit_sel), .read_done_n_oe(read_done_n_oe), .dout_n_oe(dout_n_oe));

/* nwm_mem_model.sv */
`timescale 1ns/1ps
module nwm_mem_model (
  // host pins
  input wire logic clk,
  input wire logic strobe,
  input wire logic rd_wr_n,
  input wire logic [11:0] addr,
  input wire logic [17:0] din,
  input wire logic [3:0] unit_sel,
  input wire logic slow,
  // open-collector pulls, 1 pulls line low
  output logic done_pull,
  output logic [17:0] dout_pull
);
  logic [17:0] mem [4096];
  int writes = 0;
  int reads = 0;
  int last_run = 0;
  // sample levels half a cycle after strobe rise
  initial begin
    done_pull = 1'b0;
    dout_pull = 18'h0_0000;
    forever begin
      @(posedge strobe);
      @(negedge clk);
      if (unit_sel != 4'hf) continue;
      if (!rd_wr_n) begin
        mem[addr] = din;
        writes++;
        last_run = reads ? reads : last_run;
        reads = 0;
      end else begin
        reads++;
        repeat (slow ? 40 : 4) @(posedge clk);
        dout_pull <= mem[addr];
        done_pull <= 1'b1;
        repeat (30) @(posedge clk);
        done_pull <= 1'b0;
        repeat (16) @(posedge clk);
        dout_pull <= 18'h0_0000;
      end
    end
  end
endmodule : nwm_mem_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import nwm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, strobe, rw_n, rd_o, rd_oe, d_pull;
  logic [11:0] addr;
  logic [17:0] din, dq_o, dq_oe, q_pull;
  logic [3:0] sel;
  int bad_count = 0;
  int checks_done = 0;
  int w0;
  always #5 clk = ~clk;
  // wires are pulled up; low when either side pulls
  nwm_host nwm_host_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strobe(strobe), .rd_wr_n(rw_n), .addr(addr), .data_input_line(din),
    .unit_sel(sel), .read_done_n_i(~(d_pull | (rd_oe & ~rd_o))), .read_done_n_o(rd_o),
    .read_done_n_oe(rd_oe), .dout_n_i(~(q_pull | (dq_oe & ~dq_o))), .dout_n_o(dq_o),
    .dout_n_oe(dq_oe));
  nwm_mem_model nwm_mem_model_i (.clk(clk), .strobe(strobe), .rd_wr_n(rw_n), .addr(addr),
    .din(din), .unit_sel(sel), .slow(slow), .done_pull(d_pull), .dout_pull(q_pull));
  ////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task stuck;
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish;
  endtask : stuck
  // one apb transfer, read data lands in q
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) stuck;
  endtask : apb
  // clear flags first so a stale error cannot stop the run
  task run(input logic [31:0] m);
    apb(1'b1, OFF_CTRL, m | 32'h0000_0004);
    apb(1'b1, OFF_CTRL, m | 32'h0000_0001);
  endtask : run
  task wait_stat(input int b);
    int n;
    for (n = 0; n < 3000 && q[b] !== 1'b1; n++) apb(1'b0, OFF_STAT, 32'h0000_0000);
    if (n == 3000) stuck;
  endtask : wait_stat
  // single access at a fixed address, then its window closes
  task one(input logic w, input logic [11:0] a, input logic [17:0] d);
    int n;
    apb(1'b1, OFF_ADDR, {20'h0_0000, a});
    apb(1'b1, OFF_DATA, {14'h0000, d});
    run({20'h0_0000, 4'hf, 4'h0, w, 3'b000});
    for (n = 0; n < 50 && strobe !== 1'b1; n++) @(posedge clk);
    if (n == 50) stuck;
    // a full period, so the next start is not swallowed by this gap's stop
    repeat (210) @(posedge clk);
  endtask : one
  task t_rand;
    chk(sel, 32'h0000_000f);
    apb(1'b0, 8'h18, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      one(1'b1, 12'h5a5 ^ {12{i[0]}}, 18'h2_b3c1 ^ {18{i[0]}});
      repeat (2) begin
        one(1'b0, 12'h5a5 ^ {12{i[0]}}, 18'h2_b3c1 ^ {18{i[0]}});
        apb(1'b0, OFF_RDAT, 32'h0000_0000);
        chk(q, {14'h0000, 18'h2_b3c1 ^ {18{i[0]}}});
        apb(1'b0, OFF_STAT, 32'h0000_0000);
        chk(q[0], 32'h0000_0000);
      end
    end
    $display("random access done");
  endtask : t_rand
  task t_pass;
    apb(1'b1, OFF_PER, 32'h0000_003c);
    w0 = nwm_mem_model_i.writes;
    apb(1'b1, OFF_ADDR, 32'h0000_0ffa);
    apb(1'b1, OFF_DATA, 32'h0001_0f0f);
    run(32'h0000_0f18);
    wait_stat(1);
    chk(nwm_mem_model_i.writes - w0, 32'h0000_0006);
    for (int k = 4090; k < 4096; k++) chk(nwm_mem_model_i.mem[k], 32'h0001_0f0f);
    // host reset between write and read back; the unit keeps its words
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    one(1'b0, 12'hffc, 18'h1_0f0f);
    apb(1'b0, OFF_RDAT, 32'h0000_0000);
    chk(q, 32'h0001_0f0f);
    $display("single pass done");
  endtask : t_pass
  task t_seq;
    // 166-cycle period, strobes at about 600 kHz
    apb(1'b1, OFF_PER, 32'h0000_00a5);
    for (int r = 0; r < 2; r++) begin
      w0 = nwm_mem_model_i.writes;
      apb(1'b1, OFF_ADDR, 32'h0000_0000);
      run(32'h0000_0f30 | (r << 6));
      for (int n = 0; nwm_mem_model_i.writes < w0 + 3; n++) begin
        if (n == 20000) stuck;
        @(posedge clk);
      end
      apb(1'b1, OFF_CTRL, 32'h0000_0f02);
      repeat (200) @(posedge clk);
      chk(nwm_mem_model_i.last_run, r ? 7 : 1);
      chk(nwm_mem_model_i.mem[0], 32'h0003_ffff);
      apb(1'b0, OFF_STAT, 32'h0000_0000);
      chk(q[0], 32'h0000_0000);
    end
    $display("sequential done");
  endtask : t_seq
  task t_sel;
    for (int s = 0; s < 15; s++) begin
      apb(1'b1, OFF_ADDR, 32'h0000_0123);
      run(32'h0000_0030 | (s << 8));
      wait_stat(0);
      chk(q[13:2], 32'h0000_0123);
    end
    $display("select done");
  endtask : t_sel
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_rand;
    t_pass;
    t_seq;
    t_sel;
    tally_and_finish;
  end
  initial begin
    #900_000;
    stuck;
  end
endmodule : testbench
